// >>> mrc_pkg.sv
// Package: constants for the module reset control block
`default_nettype none
package mrc_pkg;
  // Clock rate and printed times
  localparam int unsigned CLK_HZ           = 125000000;
  localparam int unsigned RST_MIN_US       = 1500;   // 1.5 ms
  localparam int unsigned RST_MAX_US       = 4000;   // 4.0 ms
  localparam int unsigned PIN_HOLD_REC_US  = 5000;   // 5 ms recommended hold by the far side
  // Low-frequency tick period, in system clocks
  localparam int unsigned LF_DIV_DEFAULT   = 3815;   // About 32.768 kHz
  localparam int unsigned LF_HZ            = CLK_HZ / LF_DIV_DEFAULT;
  // Filter length in LF ticks: least time rounded up, must stay below the longest time
  localparam int unsigned FILT_TICKS       = (RST_MIN_US * LF_HZ + 999999) / 1000000;
  // Serial bit time in system clocks and bits per frame
  localparam int unsigned BAUD_DIV_DEFAULT = 1085;   // About 115200 baud
  localparam int unsigned FRAME_BITS       = 10;     // Start, 8 data, stop
  // Reset stretch in LF ticks once all sources are gone
  localparam int unsigned STRETCH_TICKS    = 4;
  // Pad groups
  localparam int unsigned GP_W             = 6;      // General-purpose lines 7..2
  localparam int unsigned PD_IN_W          = 15;     // Input pads with weak pull-down
  localparam int unsigned OUT_PD_W         = 2;      // Audio data out, SPI peripheral out
  localparam int unsigned OUT_PU_W         = 2;      // Serial transmit, request-to-send
  // Merged reset FSM, stepped on low-frequency ticks
  typedef enum logic [1:0] {
    MRC_IDLE = 2'b01,
    MRC_RST  = 2'b10
  } mrc_state_t;
endpackage : mrc_pkg
`default_nettype wire

// >>> mrc_sync.sv
// Three-stage input synchroniser with second/third stage agreement
`default_nettype none
module mrc_sync (
  // Clock, reset and enable
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic en_i,
  // Data
  input  wire logic d_i,
  output logic      q_o
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic       q_q;
  logic       q_d;

  always_comb begin
    sh_d = sh_q;
    q_d  = q_q;
    if (en_i) begin
      sh_d = {sh_q[1:0], d_i};
      // A change counts once the second and third stages agree
      if (sh_q[1] == sh_q[2]) begin
        q_d = sh_q[2];
      end
    end
  end

  // Every source idles high at this point, so all stages reset high
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_q <= 3'h7;
      q_q  <= 1'b1;
    end else begin
      sh_q <= sh_d;
      q_q  <= q_d;
    end
  end

  assign q_o = q_q;
endmodule : mrc_sync
`default_nettype wire

// >>> mrc_reset_ctrl.sv
// Reset merger for four sources and pad default control during reset
`default_nettype none
// Overview of operation
// - Any of four sources resets the device
// - Active-low pin filtered by low-frequency clock
// - Pin reset takes effect 1.5 to 4.0 ms
// - Power-on reset with two supply thresholds
// - Reset: bidirectional pads input, outputs undriven
// - Listed input pads get weak pull-downs
// - Audio data out undriven, weak pull-down
// - Serial transmit and RTS undriven, pull-up
// - SPI peripheral out undriven, pull-down
module mrc_reset_ctrl import mrc_pkg::*; #(
  parameter int unsigned LF_DIV   = LF_DIV_DEFAULT,
  parameter int unsigned BAUD_DIV = BAUD_DIV_DEFAULT
) (
  // Clock, reset, enable
  input  wire logic                clock_i,
  input  wire logic                rst_n_i,
  input  wire logic                clk_en_i,
  // Reset sources
  input  wire logic                ext_reset_n_i,
  input  wire logic                supply_below_low_i,
  input  wire logic                supply_above_high_i,
  input  wire logic                uart_rx_i,
  input  wire logic                wdog_timeout_i,
  // Merged reset
  output logic                     sys_reset_o,
  output logic [3:0]               reset_cause_o,
  // Pad control: output enables and pulls
  output logic [GP_W-1:0]          gp_line_force_in_o,
  output logic [PD_IN_W-1:0]       in_pad_pd_o,
  output logic [OUT_PD_W-1:0]      out_pad_hiz_pd_o,
  output logic [OUT_PU_W-1:0]      out_pad_hiz_pu_o
);
  localparam int unsigned DIV_W   = $clog2(LF_DIV + 1);
  localparam int unsigned FILT_W  = $clog2(FILT_TICKS + 2);
  localparam int unsigned BRK_CNT = BAUD_DIV * (FRAME_BITS + 1);
  localparam int unsigned BRK_W   = $clog2(BRK_CNT + 2);
  localparam int unsigned STR_W   = $clog2(STRETCH_TICKS + 1);
  localparam int unsigned N_SRC   = 5;

  logic pin_s;
  logic rx_s;
  logic por_lo_s;
  logic por_hi_s;
  logic wd_s;

  // External inputs cross into the clock domain; active-high sources are
  // inverted first so every synchroniser idles at its reset level
  logic [N_SRC-1:0] src_raw;
  logic [N_SRC-1:0] src_s;

  assign src_raw = {~wdog_timeout_i, supply_above_high_i, ~supply_below_low_i, uart_rx_i,
                    ext_reset_n_i};

  for (genvar g = 0; g < N_SRC; g++) begin : g_sync
    mrc_sync mrc_sync_i (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .en_i   (clk_en_i),
      .d_i    (src_raw[g]),
      .q_o    (src_s[g])
    );
  end

  assign pin_s    = src_s[0];
  assign rx_s     = src_s[1];
  assign por_lo_s = src_s[2];
  assign por_hi_s = src_s[3];
  assign wd_s     = src_s[4];

  // Low-frequency tick divider
  logic [DIV_W-1:0]  div_q;
  logic [DIV_W-1:0]  div_d;
  logic              tick;
  // Pin filter
  logic [FILT_W-1:0] filt_q;
  logic [FILT_W-1:0] filt_d;
  logic              pin_req_q;
  logic              pin_req_d;
  // Power-on hysteresis
  logic              por_q;
  logic              por_d;
  // Break detector
  logic [BRK_W-1:0]  brk_q;
  logic [BRK_W-1:0]  brk_d;
  logic              brk_req_q;
  logic              brk_req_d;
  // Merged reset
  mrc_state_t        st_q;
  mrc_state_t        st_d;
  logic [STR_W-1:0]  str_q;
  logic [STR_W-1:0]  str_d;
  logic [3:0]        cause_q;
  logic [3:0]        cause_d;
  logic [3:0]        req;
  logic              any_req;

  assign tick = (div_q == DIV_W'(LF_DIV - 1));
  assign req  = {~wd_s, brk_req_q, por_q, pin_req_q};
  assign any_req = |req;

  always_comb begin
    div_d     = div_q;
    filt_d    = filt_q;
    pin_req_d = pin_req_q;
    por_d     = por_q;
    brk_d     = brk_q;
    brk_req_d = brk_req_q;
    st_d      = st_q;
    str_d     = str_q;
    cause_d   = cause_q;
    if (clk_en_i) begin
      div_d = tick ? '0 : div_q + DIV_W'(1);
      // Pin must stay low for FILT_TICKS ticks; tick jitter keeps it below 4.0 ms
      if (pin_s) begin
        filt_d    = '0;
        pin_req_d = 1'b0;
      end else if (tick) begin
        if (filt_q >= FILT_W'(FILT_TICKS)) begin
          pin_req_d = 1'b1;
        end else begin
          filt_d = filt_q + FILT_W'(1);
        end
      end
      // Asserts below low threshold, releases only above high threshold
      if (!por_lo_s) begin
        por_d = 1'b1;
      end else if (por_hi_s) begin
        por_d = 1'b0;
      end
      // Break: receive held low longer than one frame plus one bit (11 bit times)
      if (rx_s) begin
        brk_d     = '0;
        brk_req_d = 1'b0;
      end else if (brk_q >= BRK_W'(BRK_CNT)) begin
        brk_req_d = 1'b1;
      end else begin
        brk_d = brk_q + BRK_W'(1);
      end
      // Merged reset aligned to LF ticks, held while any source is active
      unique case (st_q)
        MRC_IDLE: begin
          if (any_req && tick) begin
            st_d    = MRC_RST;
            str_d   = STR_W'(STRETCH_TICKS);
            cause_d = req;
          end
        end
        MRC_RST: begin
          cause_d = cause_q | req;
          if (any_req) begin
            str_d = STR_W'(STRETCH_TICKS);
          end else if (tick) begin
            if (str_q == '0) begin
              st_d = MRC_IDLE;
            end else begin
              str_d = str_q - STR_W'(1);
            end
          end
        end
        default: st_d = MRC_RST;
      endcase
    end
  end

  // Power-up comes out of reset with the device held (far side settles supplies)
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q     <= '0;
      filt_q    <= '0;
      pin_req_q <= 1'b0;
      por_q     <= 1'b1;
      brk_q     <= '0;
      brk_req_q <= 1'b0;
      st_q      <= MRC_RST;
      str_q     <= STR_W'(STRETCH_TICKS);
      cause_q   <= 4'h0;
    end else begin
      div_q     <= div_d;
      filt_q    <= filt_d;
      pin_req_q <= pin_req_d;
      por_q     <= por_d;
      brk_q     <= brk_d;
      brk_req_q <= brk_req_d;
      st_q      <= st_d;
      str_q     <= str_d;
      cause_q   <= cause_d;
    end
  end

  // Registered outputs follow the next state so pads switch with the reset
  logic in_rst_d;
  logic sys_q;
  logic [GP_W-1:0]     gp_q;
  logic [PD_IN_W-1:0]  inpd_q;
  logic [OUT_PD_W-1:0] opd_q;
  logic [OUT_PU_W-1:0] opu_q;
  logic [3:0]          cause_out_q;

  assign in_rst_d = (st_d == MRC_RST);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sys_q       <= 1'b1;
      gp_q        <= '1;
      inpd_q      <= '1;
      opd_q       <= '1;
      opu_q       <= '1;
      cause_out_q <= 4'h0;
    end else begin
      sys_q       <= in_rst_d;
      gp_q        <= {GP_W{in_rst_d}};
      inpd_q      <= {PD_IN_W{in_rst_d}};
      opd_q       <= {OUT_PD_W{in_rst_d}};
      opu_q       <= {OUT_PU_W{in_rst_d}};
      cause_out_q <= cause_d;
    end
  end

  assign sys_reset_o        = sys_q;
  assign reset_cause_o      = cause_out_q;
  assign gp_line_force_in_o = gp_q;
  assign in_pad_pd_o        = inpd_q;
  assign out_pad_hiz_pd_o   = opd_q;
  assign out_pad_hiz_pu_o   = opu_q;
endmodule : mrc_reset_ctrl
`default_nettype wire

// >>> mrc_reset_ctrl_assertions.sv
// Port-level checker for the reset merger
`default_nettype none
module mrc_reset_ctrl_assertions import mrc_pkg::*; #(
  parameter int unsigned LF_DIV   = LF_DIV_DEFAULT,
  parameter int unsigned BAUD_DIV = BAUD_DIV_DEFAULT
) (
  input wire logic                clock_i,
  input wire logic                rst_n_i,
  input wire logic                clk_en_i,
  input wire logic                ext_reset_n_i,
  input wire logic                supply_below_low_i,
  input wire logic                supply_above_high_i,
  input wire logic                uart_rx_i,
  input wire logic                wdog_timeout_i,
  input wire logic                sys_reset_o,
  input wire logic [3:0]          reset_cause_o,
  input wire logic [GP_W-1:0]     gp_line_force_in_o,
  input wire logic [PD_IN_W-1:0]  in_pad_pd_o,
  input wire logic [OUT_PD_W-1:0] out_pad_hiz_pd_o,
  input wire logic [OUT_PU_W-1:0] out_pad_hiz_pu_o
);
  // Bounds carry slack for synchroniser latency and tick alignment
  localparam int unsigned PIN_MAX = (FILT_TICKS + 3) * LF_DIV + 16;
  localparam int unsigned BRK_MAX = BAUD_DIV * (FRAME_BITS + 1) + 2 * LF_DIV + 16;
  int unsigned pin_q;
  int unsigned rx_q;
  int unsigned quiet_q;
  logic        quiet;
  // A pin low shorter than the filter is no request, so it does not break the quiet run
  assign quiet = (pin_q < FILT_TICKS * LF_DIV) && uart_rx_i && !wdog_timeout_i
                 && !supply_below_low_i && supply_above_high_i;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_q <= 0;
      rx_q <= 0;
      quiet_q <= 0;
    end else begin
      pin_q <= ext_reset_n_i ? 0 : pin_q + 1;
      rx_q <= uart_rx_i ? 0 : rx_q + 1;
      quiet_q <= quiet ? quiet_q + 1 : 0;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_pin; {gp_line_force_in_o, in_pad_pd_o} == {(GP_W + PD_IN_W){sys_reset_o}}; endproperty
  a_pin: assert property (p_pin) else $error("input pads off reset");
  property p_pout; {out_pad_hiz_pd_o, out_pad_hiz_pu_o} == {4{sys_reset_o}}; endproperty
  a_pout: assert property (p_pout) else $error("output pads off reset");
  property p_wdog; (wdog_timeout_i && clk_en_i) [*8] |-> ##[0:8] sys_reset_o; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog reset late");
  property p_por; supply_below_low_i [*8] |-> ##[0:8] sys_reset_o; endproperty
  a_por: assert property (p_por) else $error("supply reset late");
  property p_cause; $rose(sys_reset_o) |-> reset_cause_o != 4'h0; endproperty
  a_cause: assert property (p_cause) else $error("reset without cause");
  property p_pinmax; pin_q == PIN_MAX |-> sys_reset_o; endproperty
  a_pinmax: assert property (p_pinmax) else $error("pin reset late");
  property p_brk; rx_q == BRK_MAX |-> sys_reset_o; endproperty
  a_brk: assert property (p_brk) else $error("break reset late");
  property p_hold; $fell(sys_reset_o) |-> quiet_q >= STRETCH_TICKS * LF_DIV; endproperty
  a_hold: assert property (p_hold) else $error("reset dropped early");
endmodule : mrc_reset_ctrl_assertions
`default_nettype wire

// >>> mrc_pin_model.sv
// Board reset circuit driving the active-low reset pin
`default_nettype none
module mrc_pin_model #(
  parameter int unsigned PWRUP = 40
) (
  input wire logic        clock_i,
  input wire logic        go_i,
  input wire logic [15:0] len_i,
  output logic            ext_reset_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Held low from power-up until supplies have settled
  logic [15:0] cnt_q = 16'(PWRUP);
  always @(posedge clock_i) begin
    if (go_i) begin
      cnt_q <= len_i;
    end else if (cnt_q != 16'h0) begin
      cnt_q <= cnt_q - 16'h1;
    end
  end
  // Pin has a pull-up, so a released pin reads high
  assign ext_reset_n_o = (cnt_q == 16'h0);
endmodule : mrc_pin_model
`default_nettype wire

// >>> mrc_reset_ctrl_bench.sv
// Self-checking bench for the reset merger
`default_nettype none
module mrc_reset_ctrl_bench import mrc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned LFD = 4;
  logic clock_i = 0, rst_n_i = 0, clk_en_i = 1, ext_reset_n_i, supply_below_low_i = 0;
  logic supply_above_high_i = 1, uart_rx_i = 1, wdog_timeout_i = 0, go = 0, sys_reset_o;
  logic [15:0]         len = 16'h0;
  logic [3:0]          reset_cause_o;
  logic [GP_W-1:0]     gp_line_force_in_o;
  logic [PD_IN_W-1:0]  in_pad_pd_o;
  logic [OUT_PD_W-1:0] out_pad_hiz_pd_o;
  logic [OUT_PU_W-1:0] out_pad_hiz_pu_o;
  int n_mismatch = 0, total_checks = 0, cyc = 0, t;
  always #4 clock_i = ~clock_i;
  mrc_reset_ctrl #(.LF_DIV(LFD), .BAUD_DIV(4)) mrc_reset_ctrl_i (.clock_i, .rst_n_i, .clk_en_i,
    .ext_reset_n_i, .supply_below_low_i, .supply_above_high_i, .uart_rx_i, .wdog_timeout_i,
    .sys_reset_o, .reset_cause_o, .gp_line_force_in_o, .in_pad_pd_o, .out_pad_hiz_pd_o,
    .out_pad_hiz_pu_o);
  mrc_pin_model mrc_pin_model_i (.clock_i, .go_i(go), .len_i(len), .ext_reset_n_o(ext_reset_n_i));
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [24:0] pads(input logic r);
    return {25{r}};
  endfunction : pads
  // Bounded wait; a hang shows up as a pad mismatch
  task automatic wait_for(input logic v);
    t = 0;
    while (sys_reset_o !== v && t < 2000) begin
      tick(1);
      t++;
    end
    check(sys_reset_o, v);
    check({gp_line_force_in_o, in_pad_pd_o, out_pad_hiz_pd_o, out_pad_hiz_pu_o}, pads(v));
  endtask : wait_for
  task automatic pin(input int n);
    len = 16'(n);
    go = 1;
    tick(1);
    go = 0;
  endtask : pin
  task automatic results;
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    void'($urandom(6));
    tick(2);
    rst_n_i = 1;
    wait_for(0);
    // Enable low freezes the merger: a watchdog request waits for it
    clk_en_i = 0;
    wdog_timeout_i = 1;
    tick(40);
    check(sys_reset_o, 0);
    clk_en_i = 1;
    wait_for(1);
    check(t >= 4, 1);
    check(reset_cause_o[3], 1);
    wdog_timeout_i = 0;
    wait_for(0);
    for (int i = 0; i < 4; i++) begin
      pin(20 + $urandom % 150);
      tick(300);
      check(sys_reset_o, 0);
      uart_rx_i = 0;
      tick(5 + $urandom % 35);
      uart_rx_i = 1;
      tick(60);
      check(sys_reset_o, 0);
    end
    for (int s = 0; s < 4; s++) begin
      case (s)
        0: pin(300);
        1: {supply_below_low_i, supply_above_high_i} = 2'b10;
        2: uart_rx_i = 0;
        default: wdog_timeout_i = 1;
      endcase
      wait_for(1);
      check(reset_cause_o[s], 1);
      if (s == 0) check(t >= FILT_TICKS * LFD && t <= (FILT_TICKS + 3) * LFD + 12, 1);
      case (s)
        1: begin
          supply_below_low_i = 0;
          tick(100);
          check(sys_reset_o, 1);
          supply_above_high_i = 1;
        end
        2: uart_rx_i = 1;
        3: wdog_timeout_i = 0;
        default: ;
      endcase
      wait_for(0);
      check(s == 0 || t >= STRETCH_TICKS * LFD, 1);
    end
    wdog_timeout_i = 1;
    tick(20);
    rst_n_i = 0;
    tick(1);
    check({sys_reset_o, reset_cause_o}, 5'h10);
    wdog_timeout_i = 0;
    rst_n_i = 1;
    wait_for(0);
    results();
  end
endmodule : mrc_reset_ctrl_bench
bind mrc_reset_ctrl mrc_reset_ctrl_assertions #(.LF_DIV(LF_DIV), .BAUD_DIV(BAUD_DIV))
  mrc_reset_ctrl_assertions_i (.clock_i, .rst_n_i, .clk_en_i, .ext_reset_n_i,
  .supply_below_low_i, .supply_above_high_i, .uart_rx_i, .wdog_timeout_i, .sys_reset_o,
  .reset_cause_o, .gp_line_force_in_o, .in_pad_pd_o, .out_pad_hiz_pd_o, .out_pad_hiz_pu_o);
`default_nettype wire
